/* core/agt_params.svh */
`ifndef AGT_PARAMS_SVH
`define AGT_PARAMS_SVH
// Register byte offsets on the Wishbone bus.
`define AGT_OFS_CTRL 8'h00
`define AGT_OFS_CONFIG 8'h04
`define AGT_OFS_STATUS 8'h08
`define AGT_OFS_TQLIM 8'h0c
`define AGT_OFS_PARAM 8'h80
// Control word fields.
`define AGT_CTRL_TUNE 0
`define AGT_CTRL_FIT 1
// Configuration fields and reset value.
`define AGT_CFG_MODE_LSB 0
`define AGT_CFG_SEMI 4
`define AGT_CFG_PAT_LSB 5
`define AGT_CFG_RST 32'h0000_0000
`define AGT_TQLIM_RST 16'h012c
// Control mode codes.
`define AGT_MODE_MAX 4'h5
`define AGT_MODE_SEMI_A 4'h6
`define AGT_MODE_SEMI_B 4'ha
// Parameter bank layout: 0..14 tuned, 16..26 fixed, then fit gain.
`define AGT_NPARAM 32
`define AGT_NTUNED 15
`define AGT_P_INERTIA 10
`define AGT_P_STIFF 11
`define AGT_P_ADAPT 12
`define AGT_P_FIX_LO 16
`define AGT_P_FIX_HI 26
`define AGT_P_FIT_MODE 28
`define AGT_P_FIT_RES 29
// Fixed values written at the end of a tuning run.
`define AGT_FIX_VFF 16'h012c
`define AGT_FIX_FFT 16'h0032
`define AGT_FIX_GACT 16'h0001
`define AGT_FIX_PSWM 16'h000a
`define AGT_FIX_PSWD 16'h001e
`define AGT_FIX_LGSW 16'h0014
`define AGT_FIX_ZERO 16'h0000
// Motion pattern.
`define AGT_MAX_CYCLES 3'h5
`define AGT_DOUBLE_FROM 3'h3
`define AGT_ACCEL_BASE 16'h0010
`define AGT_CYCLE_MS 64'd15000
`define AGT_CLK_KHZ 64'd250000
`define AGT_CYCLE_CLKS (`AGT_CYCLE_MS * `AGT_CLK_KHZ)
`endif

/* core/agt_pkg.sv */
package agt_pkg;
  // Sequencer states.
  typedef enum logic [1:0] {
    AGT_IDLE = 2'b00,
    AGT_RUN = 2'b01,
    AGT_APPLY = 2'b10,
    AGT_FIT = 2'b11
  } agt_state_t;
endpackage : agt_pkg

/* core/agt_sequencer.sv */
`timescale 1ns/1ps
`include "agt_params.svh"
module agt_sequencer #(
  parameter logic [31:0] CYCLE_CLKS = 32'(`AGT_CYCLE_CLKS)
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Drive state.
  input wire logic servo_on_i,
  input wire logic dev_clear_i,
  input wire logic alarm_i,
  input wire logic [15:0] torque_fb_i,
  input wire logic cw_prohibit_i,
  input wire logic ccw_prohibit_i,
  // Front panel and fit gain search.
  input wire logic key_press_i,
  input wire logic fit_done_i,
  // Motion and torque commands.
  output logic motion_active_o,
  output logic motion_dir_o,
  output logic [15:0] accel_cmd_o,
  output logic [15:0] torque_limit_o,
  output logic drive_inhibit_o
);

  agt_pkg::agt_state_t state_r;
  logic [31:0] cfg_r;
  logic [15:0] tqlim_r;
  logic [15:0] param_r [`AGT_NPARAM];
  logic [2:0] cycle_r;
  logic [31:0] cyc_cnt_r;
  logic [31:0] seg_cnt_r;
  logic [3:0] accel_sh_r;
  logic [31:0] tq_sum_r;
  logic sat_seen_r;
  logic busy_r, done_r, err_r, fail_r, refused_r, fit_err_r;
  logic [15:0] inertia_r;
  logic wr_req, rd_req, start_tune, start_fit, entry_ok, abort;
  logic cycle_end, seg_end, apply_ok, run_last;
  logic [3:0] mode, stiff;
  logic [15:0] tq_abs, est;
  logic [31:0] seg_len;

  assign wr_req = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  assign rd_req = cyc_i && stb_i && !we_i && !ack_o;
  assign start_tune = wr_req && adr_i == `AGT_OFS_CTRL
                      && dat_i[`AGT_CTRL_TUNE];
  assign start_fit = wr_req && adr_i == `AGT_OFS_CTRL
                     && dat_i[`AGT_CTRL_FIT] && !dat_i[`AGT_CTRL_TUNE];
  assign mode = cfg_r[`AGT_CFG_MODE_LSB +: 4];
  assign stiff = param_r[`AGT_P_STIFF][3:0];

  // Entry check: sampled only in the start cycle, never rechecked.
  assign entry_ok = (mode <= `AGT_MODE_MAX
                     || ((mode == `AGT_MODE_SEMI_A
                          || mode == `AGT_MODE_SEMI_B)
                         && cfg_r[`AGT_CFG_SEMI]))
                    && servo_on_i && !dev_clear_i;
  assign abort = alarm_i || !servo_on_i || dev_clear_i;

  // Each pattern selection splits a cycle into more reversals.
  // Three bits for the shift, so the last pattern does not wrap to zero.
  assign seg_len = CYCLE_CLKS >> (3'(cfg_r[`AGT_CFG_PAT_LSB +: 2]) + 3'd1);
  assign cycle_end = cyc_cnt_r == CYCLE_CLKS - 32'd1;
  // The cycle now running is the last one of the run.
  assign run_last = cycle_r == `AGT_MAX_CYCLES
                    || (sat_seen_r && cycle_r >= `AGT_DOUBLE_FROM);
  assign seg_end = seg_cnt_r == seg_len - 32'd1;
  assign tq_abs = torque_fb_i[15] ? 16'(-torque_fb_i) : torque_fb_i;
  // Mean torque per unit of acceleration stands in for load inertia.
  assign est = 16'(tq_sum_r >> (5'd16 + 5'(accel_sh_r)));
  assign apply_ok = inertia_r != 16'h0000;

  // Bus acknowledge: one cycle after the strobe, dropped the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Read data; unmapped addresses read as zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd_req) begin
      if (adr_i >= `AGT_OFS_PARAM) begin
        dat_o <= {16'h0000, param_r[adr_i[6:2]]};
      end else begin
        unique case (adr_i)
          `AGT_OFS_CONFIG: dat_o <= cfg_r;
          `AGT_OFS_STATUS: dat_o <= {22'h000000, inertia_r[15:12] == 4'h0,
                                     cycle_r, fit_err_r, refused_r,
                                     fail_r, err_r, done_r, busy_r};
          `AGT_OFS_TQLIM: dat_o <= {16'h0000, tqlim_r};
          default: dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Configuration and torque limit; frozen while a run is active.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= `AGT_CFG_RST;
      tqlim_r <= `AGT_TQLIM_RST;
    end else if (wr_req && !busy_r) begin
      if (adr_i == `AGT_OFS_CONFIG) begin
        cfg_r <= {25'h0000000, dat_i[6:0]};
      end
      if (adr_i == `AGT_OFS_TQLIM) begin
        tqlim_r <= dat_i[15:0];
      end
    end
  end

  // Main sequencer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= agt_pkg::AGT_IDLE;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      fail_r <= 1'b0;
      refused_r <= 1'b0;
      fit_err_r <= 1'b0;
    end else begin
      unique case (state_r)
        agt_pkg::AGT_IDLE: begin
          if (start_tune || start_fit) begin
            done_r <= 1'b0;
            err_r <= 1'b0;
            fail_r <= 1'b0;
            fit_err_r <= 1'b0;
            refused_r <= !entry_ok;
            if (entry_ok) begin
              busy_r <= 1'b1;
              state_r <= start_tune ? agt_pkg::AGT_RUN
                                    : agt_pkg::AGT_FIT;
            end
          end
        end
        agt_pkg::AGT_RUN: begin
          if (abort) begin
            err_r <= 1'b1;
            busy_r <= 1'b0;
            state_r <= agt_pkg::AGT_IDLE;
          end else if (cycle_end && run_last) begin
            state_r <= agt_pkg::AGT_APPLY;
          end
        end
        agt_pkg::AGT_APPLY: begin
          fail_r <= !apply_ok;
          done_r <= 1'b1;
          busy_r <= 1'b0;
          state_r <= agt_pkg::AGT_IDLE;
        end
        agt_pkg::AGT_FIT: begin
          if (key_press_i || abort) begin
            fit_err_r <= 1'b1;
            busy_r <= 1'b0;
            state_r <= agt_pkg::AGT_IDLE;
          end else if (fit_done_i) begin
            done_r <= 1'b1;
            busy_r <= 1'b0;
            state_r <= agt_pkg::AGT_IDLE;
          end
        end
      endcase
    end
  end

  // Self-generated motion: cycle and reversal timing.
  always_ff @(posedge clk_i) begin
    if (rst_i || state_r != agt_pkg::AGT_RUN) begin
      cyc_cnt_r <= 32'h0000_0000;
      seg_cnt_r <= 32'h0000_0000;
      motion_dir_o <= 1'b0;
      accel_sh_r <= 4'h0;
    end else begin
      cyc_cnt_r <= cycle_end ? 32'h0000_0000 : cyc_cnt_r + 32'd1;
      seg_cnt_r <= (seg_end || cycle_end) ? 32'h0000_0000
                                          : seg_cnt_r + 32'd1;
      motion_dir_o <= cycle_end ? 1'b0 : motion_dir_o ^ seg_end;
      if (cycle_end) begin
        // Doubling is held back when torque already reached the limit.
        if (cycle_r + 3'h1 >= `AGT_DOUBLE_FROM && !sat_seen_r) begin
          accel_sh_r <= accel_sh_r + 4'h1;
        end
      end
    end
  end

  // Cycle number: restarts at one when a run starts and keeps the count of
  // the last run afterwards, so status still shows how far it got.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cycle_r <= 3'h1;
    end else if (state_r == agt_pkg::AGT_IDLE && start_tune && entry_ok) begin
      cycle_r <= 3'h1;
    end else if (state_r == agt_pkg::AGT_RUN && cycle_end && !run_last) begin
      cycle_r <= cycle_r + 3'h1;
    end
  end

  // Torque integration and inertia estimate per cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i || state_r == agt_pkg::AGT_IDLE) begin
      tq_sum_r <= 32'h0000_0000;
      sat_seen_r <= 1'b0;
      inertia_r <= 16'h0000;
    end else if (state_r == agt_pkg::AGT_RUN) begin
      if (cycle_end) begin
        inertia_r <= est;
        tq_sum_r <= 32'h0000_0000;
        sat_seen_r <= 1'b0;
      end else begin
        // Sum saturates instead of wrapping on heavy loads.
        tq_sum_r <= (tq_sum_r > 32'hffff_0000) ? tq_sum_r
                    : tq_sum_r + {16'h0000, tq_abs};
        sat_seen_r <= sat_seen_r || tq_abs >= tqlim_r;
      end
    end
  end

  // Motion and torque outputs follow the run state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      motion_active_o <= 1'b0;
      accel_cmd_o <= 16'h0000;
      torque_limit_o <= 16'h0000;
      drive_inhibit_o <= 1'b0;
    end else begin
      motion_active_o <= state_r == agt_pkg::AGT_RUN && !abort;
      accel_cmd_o <= state_r == agt_pkg::AGT_RUN
                     ? `AGT_ACCEL_BASE << accel_sh_r : 16'h0000;
      torque_limit_o <= state_r == agt_pkg::AGT_RUN
                        ? tqlim_r : 16'hffff;
      drive_inhibit_o <= state_r != agt_pkg::AGT_RUN
                         && (cw_prohibit_i || ccw_prohibit_i);
    end
  end

  // Value written into a tuned entry; gains grow with stiffness.
  function automatic logic [15:0] tuned_val(input int idx,
                                            input logic [3:0] stf,
                                            input logic [15:0] jr,
                                            input logic [15:0] old);
    logic [15:0] base;
    base = {12'h000, stf} + 16'h0001;
    unique case (idx)
      0, 5: tuned_val = 16'(base * 16'h0010);
      1, 6: tuned_val = 16'(base * 16'h000a + (jr >> 4));
      2, 7: tuned_val = 16'h03e8 >> stf[3:2];
      3, 8: tuned_val = 16'h0000;
      4, 9: tuned_val = 16'h0064 >> stf[3:2];
      `AGT_P_INERTIA: tuned_val = jr;
      `AGT_P_STIFF: tuned_val = {12'h000, stf};
      `AGT_P_ADAPT: tuned_val = old;
      13: tuned_val = 16'h0032;
      default: tuned_val = 16'h0021;
    endcase
  endfunction : tuned_val

  // Value forced into a fixed entry.
  function automatic logic [15:0] fixed_val(input int idx);
    unique case (idx)
      16: fixed_val = `AGT_FIX_VFF;
      17: fixed_val = `AGT_FIX_FFT;
      21: fixed_val = `AGT_FIX_GACT;
      22: fixed_val = `AGT_FIX_PSWM;
      23: fixed_val = `AGT_FIX_PSWD;
      24: fixed_val = `AGT_FIX_LGSW;
      default: fixed_val = `AGT_FIX_ZERO;
    endcase
  endfunction : fixed_val

  // Parameter bank: software writes, tuning and fit gain overwrite.
  for (genvar i = 0; i < `AGT_NPARAM; i++) begin : g_param
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        param_r[i] <= 16'h0000;
      end else if (state_r == agt_pkg::AGT_APPLY && apply_ok
                   && i < `AGT_NTUNED) begin
        param_r[i] <= tuned_val(i, stiff, inertia_r, param_r[i]);
      end else if (state_r == agt_pkg::AGT_APPLY && apply_ok
                   && i >= `AGT_P_FIX_LO && i <= `AGT_P_FIX_HI) begin
        param_r[i] <= fixed_val(i);
      end else if (state_r == agt_pkg::AGT_FIT && fit_done_i
                   && !key_press_i && !abort && i == `AGT_P_FIT_RES) begin
        param_r[i] <= {stiff, param_r[0][11:0]};
      end else if (wr_req && !busy_r && adr_i >= `AGT_OFS_PARAM
                   && adr_i[6:2] == 5'(i)) begin
        param_r[i] <= dat_i[15:0];
      end
    end
  end

endmodule : agt_sequencer

/* verification/agt_motor.sv */
`timescale 1ns/1ps
// Motor and load: torque follows the command one clock late.
module agt_motor (
  // Clock.
  input wire logic clk_i,
  // Drive side.
  input wire logic active_i,
  input wire logic dir_i,
  input wire logic [15:0] amp_i,
  // Load side.
  output logic [15:0] torque_o
);
  // A motor at rest gives no torque, so a stopped run reads zero.
  always_ff @(posedge clk_i) begin
    torque_o <= !active_i ? 16'h0000 : (dir_i ? -amp_i : amp_i);
  end
endmodule : agt_motor

/* verification/agt_chk.sv */
`timescale 1ns/1ps
// Port checks for the tuning sequencer.
module agt_chk #(
  parameter logic [31:0] CYCLE_CLKS = 32'h0000_0040
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic ack_o,
  // Drive state and commands.
  input wire logic servo_on_i,
  input wire logic alarm_i,
  input wire logic motion_active_o,
  input wire logic [15:0] accel_cmd_o,
  input wire logic [15:0] torque_limit_o,
  input wire logic drive_inhibit_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Clocks of one run; five cycles is the longest legal run.
  logic [31:0] run_cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || !motion_active_o)
      run_cnt_r <= 32'h0;
    else
      run_cnt_r <= run_cnt_r + 32'h1;
  end
  property p_run_len;
    run_cnt_r <= 32'(5 * CYCLE_CLKS);
  endproperty
  a_run_len: assert property (p_run_len)
    else $error("run longer than five cycles");
  property p_ack_one;
    ack_o |=> !ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack longer than one cycle");
  property p_ack_req;
    ack_o |-> $past(cyc_i && stb_i);
  endproperty
  a_ack_req: assert property (p_ack_req)
    else $error("ack without request");
  property p_abort;
    motion_active_o && (alarm_i || !servo_on_i) |=> !motion_active_o;
  endproperty
  a_abort: assert property (p_abort)
    else $error("run not ended on abort");
  property p_refuse;
    cyc_i && stb_i && we_i && !ack_o && adr_i == 8'h00 && dat_i[0]
      && !servo_on_i && !motion_active_o |-> ##2 !motion_active_o;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("run started with servo off");
  property p_inhibit;
    motion_active_o |-> !drive_inhibit_o;
  endproperty
  a_inhibit: assert property (p_inhibit)
    else $error("prohibit honoured during run");
  property p_tq_lim;
    motion_active_o |-> torque_limit_o != 16'hffff;
  endproperty
  a_tq_lim: assert property (p_tq_lim)
    else $error("torque unlimited during run");
  property p_accel_set;
    motion_active_o |-> accel_cmd_o inside
      {16'h0000, 16'h0010, 16'h0020, 16'h0040, 16'h0080};
  endproperty
  a_accel_set: assert property (p_accel_set)
    else $error("acceleration out of range");
  property p_accel_dbl;
    motion_active_o && $past(motion_active_o) && $past(accel_cmd_o) != 0
      && $changed(accel_cmd_o) |-> accel_cmd_o == $past(accel_cmd_o) << 1;
  endproperty
  a_accel_dbl: assert property (p_accel_dbl)
    else $error("acceleration step not a doubling");
  property p_accel_off;
    $fell(motion_active_o) |-> ##[0:2] accel_cmd_o == 16'h0000;
  endproperty
  a_accel_off: assert property (p_accel_off)
    else $error("acceleration left on after run");
endmodule : agt_chk
bind agt_sequencer agt_chk #(.CYCLE_CLKS(CYCLE_CLKS)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o), .servo_on_i(servo_on_i),
  .alarm_i(alarm_i), .motion_active_o(motion_active_o),
  .accel_cmd_o(accel_cmd_o), .torque_limit_o(torque_limit_o),
  .drive_inhibit_o(drive_inhibit_o));

/* verification/testbench.sv */
`timescale 1ns/1ps
// Drives the sequencer over its register bus and checks the results.
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0;
  logic servo_on_i = 1'b1;
  logic dev_clear_i = 1'b0;
  logic alarm_i = 1'b0;
  logic cw_prohibit_i = 1'b0;
  logic key_press_i = 1'b0;
  logic fit_done_i = 1'b0;
  logic [15:0] amp = 16'h0;
  logic [31:0] dat_o, s, g0, g1;
  logic ack_o, motion_active_o, motion_dir_o, drive_inhibit_o, ok;
  logic [15:0] torque_fb_i, accel_cmd_o, torque_limit_o;
  logic [31:0] keep[15];
  logic [15:0] fix[11] = '{16'h012c, 16'h0032, 16'h0, 16'h0, 16'h0,
    16'h0001, 16'h000a, 16'h001e, 16'h0014, 16'h0, 16'h0};
  int n_errors = 0;
  int checked = 0;
  // Clock of 4 ns.
  always #2 clk_i = ~clk_i;
  agt_sequencer #(.CYCLE_CLKS(32'h0000_0040)) dut (.clk_i, .rst_i, .cyc_i,
    .stb_i, .we_i, .adr_i, .sel_i(4'hf), .dat_i, .dat_o, .ack_o,
    .servo_on_i, .dev_clear_i, .alarm_i, .torque_fb_i, .cw_prohibit_i,
    .ccw_prohibit_i(cw_prohibit_i), .key_press_i, .fit_done_i,
    .motion_active_o, .motion_dir_o, .accel_cmd_o, .torque_limit_o,
    .drive_inhibit_o);
  agt_motor u_motor (.clk_i, .active_i(motion_active_o),
    .dir_i(motion_dir_o), .amp_i(amp), .torque_o(torque_fb_i));
  // One classic cycle; the request holds until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : wb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd
  // Polls status; the count bounds a run that never ends.
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      wb(1'b0, 8'h08, 32'h0, s);
      n++;
    end while (s[0] !== 1'b0 && n < 400);
    chk(32'(s[0]), 32'h0);
  endtask : wait_idle
  // Motor amplitude and stiffness set, pattern set, then start.
  task automatic go(input logic [15:0] a, input logic [3:0] st);
    amp <= a;
    wr(8'hac, {28'h0, st});
    wr(8'h04, 32'h20);
    wr(8'h00, 32'h1);
  endtask : go
  task automatic complete_run();
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  // Watchdog cuts a hang short.
  initial begin
    repeat (80000) @(posedge clk_i);
    n_errors++;
    complete_run();
  end
  // Test sequence.
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(32'(torque_limit_o), 32'hffff);
    rd(8'h0c, 32'h012c);
    rd(8'h40, 32'h0);
    $display("test reset done");
    for (int m = 0; m < 32; m++) begin
      ok = m[3:0] <= 5 || (m[4] && (m[3:0] == 6 || m[3:0] == 10));
      wr(8'h04, 32'(m));
      wr(8'h00, 32'h1);
      wb(1'b0, 8'h08, 32'h0, s);
      chk(32'(s[0]), 32'(ok));
      if (!ok) chk(32'(s[4]), 32'h1);
      case (m % 3)
        0: alarm_i <= 1'b1;
        1: servo_on_i <= 1'b0;
        default: dev_clear_i <= 1'b1;
      endcase
      wait_idle();
      if (ok) chk(32'(s[2]), 32'h1);
      alarm_i <= 1'b0;
      servo_on_i <= 1'b1;
      dev_clear_i <= 1'b0;
    end
    for (int k = 0; k < 2; k++) begin
      servo_on_i <= k[0];
      dev_clear_i <= k[0];
      wr(8'h04, 32'h0);
      wr(8'h00, 32'h1);
      wb(1'b0, 8'h08, 32'h0, s);
      chk(32'(s[4:0] & 5'h11), 32'h10);
    end
    servo_on_i <= 1'b1;
    dev_clear_i <= 1'b0;
    $display("test entry done");
    wr(8'h0c, 32'h7000);
    cw_prohibit_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk(32'(drive_inhibit_o), 32'h1);
    go(16'h4000, 4'h2);
    repeat (3) @(posedge clk_i);
    chk(32'(torque_limit_o), 32'h7000);
    chk(32'(drive_inhibit_o), 32'h0);
    chk(32'(accel_cmd_o), 32'h10);
    ok = motion_dir_o;
    repeat (16) @(posedge clk_i);
    chk(32'(motion_dir_o), 32'(!ok));
    wait_idle();
    chk(32'({s[8:6], s[3], s[1]}), 32'h15);
    wb(1'b0, 8'ha8, 32'h0, s);
    chk(32'(s != 0), 32'h1);
    wb(1'b0, 8'h80, 32'h0, g0);
    for (int i = 0; i < 11; i++)
      rd(8'(8'hc0 + 4 * i), 32'(fix[i]));
    go(16'h4000, 4'hc);
    wait_idle();
    wb(1'b0, 8'h80, 32'h0, g1);
    chk(32'(g1 > g0), 32'h1);
    wr(8'h0c, 32'h3000);
    go(16'h4000, 4'h2);
    wait_idle();
    chk(32'({s[8:6], s[1]}), 32'h7);
    $display("test run done");
    wr(8'h00, 32'h2);
    key_press_i <= 1'b1;
    @(posedge clk_i);
    key_press_i <= 1'b0;
    wb(1'b0, 8'h08, 32'h0, s);
    chk(32'(s[5]), 32'h1);
    wb(1'b0, 8'h80, 32'h0, g1);
    wr(8'h00, 32'h2);
    fit_done_i <= 1'b1;
    @(posedge clk_i);
    fit_done_i <= 1'b0;
    rd(8'hf4, {16'h0, 4'h2, g1[11:0]});
    wr(8'hf4, 32'h0);
    rd(8'hf4, 32'h0);
    $display("test fit done");
    // Settings copied out after a good result, as the operator keeps them.
    for (int i = 0; i < 15; i++)
      wb(1'b0, 8'(8'h80 + 4 * i), 32'h0, keep[i]);
    go(16'h0000, 4'h2);
    wait_idle();
    chk(32'(s[3]), 32'h1);
    for (int i = 0; i < 15; i++)
      rd(8'(8'h80 + 4 * i), keep[i]);
    $display("test estimate fail done");
    complete_run();
  end
endmodule : testbench
